// file: rtl/ssp_pkg.sv
// shared constants and types of the serial shift port
package ssp_pkg;

   // ==========================================================
   // register indices on the peripheral register port
   localparam logic [3:0] SSP_CTRL_ADDR = 4'h1;  // serial_control
   localparam logic [3:0] SSP_DATA_ADDR = 4'h2;  // serial_shift_data

   // ==========================================================
   // serial_control field positions
   localparam int SSP_CTRL_START_BIT = 0;  // write: start, read: end flag
   localparam int SSP_CTRL_EXTCLK_BIT = 1;  // 1 = external shift clock
   localparam int SSP_CTRL_SPARE_BIT = 2;  // stored, no function
   localparam int SSP_CTRL_DIR_BIT = 3;  // 1 = bidir pin transmits

   // ==========================================================
   // values after reset
   localparam logic [2:0] SSP_CTRL_RESET = 3'h0;  // internal clock, input
   localparam logic [7:0] SSP_DATA_RESET = 8'h00;
   localparam logic [3:0] SSP_RDATA_RESET = 4'h0;

   // ==========================================================
   // byte framing
   localparam int SSP_BYTE_BITS = 8;
   localparam logic [2:0] SSP_LAST_BIT = 3'(SSP_BYTE_BITS - 1);

   // ==========================================================
   // timing: the core clock is the oscillator, one instruction is six
   localparam int SSP_OSC_PER_INSTR = 6;
   localparam logic [2:0] SSP_INSTR_LAST = 3'(SSP_OSC_PER_INSTR - 1);
   localparam int SSP_GUARD_INSTR = 2;  // quiet time after start
   localparam int SSP_GUARD_CLKS = SSP_GUARD_INSTR * SSP_OSC_PER_INSTR;
   localparam logic [3:0] SSP_GUARD_LOAD = 4'(SSP_GUARD_CLKS);

   // ==========================================================
   // transfer sequencer states
   typedef enum logic [1:0] {
      SSP_IDLE,
      SSP_PEND,
      SSP_SHIFT
   } ssp_state_t;

endpackage

// file: rtl/ssp_fifo.sv
// receive byte fifo with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none

module ssp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic             clk,
   input  wire logic             reset,
   input  wire logic [WIDTH-1:0] inData,
   input  wire logic             inValid,
   output      logic             inReady,
   output      logic [WIDTH-1:0] outData,
   output      logic             outValid,
   input  wire logic             outReady
);

   // depth is taken as a power of two so the pointers wrap by themselves
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wrPtr_q;
   logic [AW-1:0]    wrPtr_d;
   logic [AW-1:0]    rdPtr_q;
   logic [AW-1:0]    rdPtr_d;
   logic [AW:0]      count_q;
   logic [AW:0]      count_d;
   logic             push;
   logic             pop;

   // ==========================================================
   // flags and pointer updates
   assign inReady  = (count_q != (AW+1)'(DEPTH));
   assign outValid = (count_q != '0);
   assign outData  = mem[rdPtr_q];
   assign push     = inValid & inReady;
   assign pop      = outValid & outReady;

   always_comb begin
      wrPtr_d = push ? wrPtr_q + 1'b1 : wrPtr_q;
      rdPtr_d = pop ? rdPtr_q + 1'b1 : rdPtr_q;
      count_d = count_q;
      if (push & ~pop) begin
         count_d = count_q + 1'b1;
      end else if (pop & ~push) begin
         count_d = count_q - 1'b1;
      end
   end

   // storage is written only at the entry the write pointer names
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wrPtr_q] <= inData;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         count_q <= '0;
      end else begin
         wrPtr_q <= wrPtr_d;
         rdPtr_q <= rdPtr_d;
         count_q <= count_d;
      end
   end

endmodule // ssp_fifo

`default_nettype wire

// file: rtl/ssp_serial_port.sv
// eight-bit serial shift port with nibble register access
`timescale 1ns/1ps
`default_nettype none

module ssp_serial_port
   import ssp_pkg::*;
#(
   parameter bit MSB_FIRST  = 1'b1,
   parameter int PRESC_DIV  = 2,
   parameter int FIFO_DEPTH = 16
) (
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic [3:0] regAddr,
   input  wire logic       regWrite,
   input  wire logic       regRead,
   input  wire logic [3:0] regWdata,
   input  wire logic       ptrLsb,
   output      logic [3:0] regRdata,
   input  wire logic       prescalerStop,
   input  wire logic       sckIn,
   output      logic       sckOut,
   output      logic       sckOe,
   output      logic       serialOutPin,
   input  wire logic       bidirDataIn,
   output      logic       bidirDataOut,
   output      logic       bidirDataOe,
   output      logic       serialIrq,
   output      logic [7:0] rxByte,
   output      logic       rxValid,
   input  wire logic       rxReady
);

   // half a shift-clock period counted in instruction ticks
   localparam int HALF = PRESC_DIV / 2;
   localparam int PW = (HALF > 1) ? $clog2(HALF) : 1;
   localparam logic [PW-1:0] PRESC_LAST = PW'(HALF - 1);

   // ==========================================================
   // pin synchronisers
   logic sckS1_q;
   logic sckS2_q;
   logic sckS3_q;
   logic datS1_q;
   logic datS2_q;

   // the first stage feeds only the second; edges use stages two, three
   always_ff @(posedge clk) begin
      if (reset) begin
         sckS1_q <= 1'b1;
         sckS2_q <= 1'b1;
         sckS3_q <= 1'b1;
         datS1_q <= 1'b0;
         datS2_q <= 1'b0;
      end else begin
         sckS1_q <= sckIn;
         sckS2_q <= sckS1_q;
         sckS3_q <= sckS2_q;
         datS1_q <= bidirDataIn;
         datS2_q <= datS1_q;
      end
   end

   // ==========================================================
   // shared prescaler
   logic [2:0]    instrCnt_q;
   logic [2:0]    instrCnt_d;
   logic [PW-1:0] prescCnt_q;
   logic [PW-1:0] prescCnt_d;
   logic          instrTick;
   logic          prescTick;

   // a stopped prescaler restarts from zero, so the first half period
   // after a restart is full length
   always_comb begin
      instrTick  = (instrCnt_q == SSP_INSTR_LAST);
      prescTick  = instrTick & (prescCnt_q == PRESC_LAST);
      instrCnt_d = instrTick ? 3'h0 : instrCnt_q + 3'h1;
      prescCnt_d = prescCnt_q;
      if (instrTick) begin
         prescCnt_d = prescTick ? '0 : prescCnt_q + 1'b1;
      end
      if (prescalerStop) begin
         instrCnt_d = 3'h0;
         prescCnt_d = '0;
         prescTick  = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         instrCnt_q <= 3'h0;
         prescCnt_q <= '0;
      end else begin
         instrCnt_q <= instrCnt_d;
         prescCnt_q <= prescCnt_d;
      end
   end

   // ==========================================================
   // control, data and transfer state
   ssp_state_t state_q;
   ssp_state_t state_d;
   logic [2:0] ctrl_q;  // bits 3..1 of serial_control
   logic [2:0] ctrl_d;
   logic [7:0] shift_q;
   logic [7:0] shift_d;
   logic [2:0] bitCnt_q;
   logic [2:0] bitCnt_d;
   logic [3:0] guard_q;
   logic [3:0] guard_d;
   logic       endFlag_q;
   logic       endFlag_d;
   logic       outBit_q;
   logic       outBit_d;
   logic       intSck_q;
   logic       intSck_d;
   logic       irq_q;
   logic       irq_d;
   logic [3:0] rdata_q;
   logic [3:0] rdata_d;
   logic       extClk;
   logic       sckFall;
   logic       sckRise;
   logic       byteDone;
   logic       ctrlWr;
   logic       dataWr;
   logic       fifoReady;

   assign extClk = ctrl_q[SSP_CTRL_EXTCLK_BIT - 1];
   assign ctrlWr = regWrite & (regAddr == SSP_CTRL_ADDR);
   assign dataWr = regWrite & (regAddr == SSP_DATA_ADDR);

   // edge selection: the peer's clock, or our own prescaled one
   always_comb begin
      if (extClk) begin
         sckFall = sckS3_q & ~sckS2_q & (guard_q == 4'h0);
         sckRise = ~sckS3_q & sckS2_q & (guard_q == 4'h0);
      end else begin
         sckFall = prescTick & intSck_q;
         sckRise = prescTick & ~intSck_q;
      end
   end

   // sequencer; register writes are applied last so they override shifting
   always_comb begin
      state_d   = state_q;
      ctrl_d    = ctrl_q;
      shift_d   = shift_q;
      bitCnt_d  = bitCnt_q;
      guard_d   = (guard_q != 4'h0) ? guard_q - 4'h1 : 4'h0;
      endFlag_d = endFlag_q;
      outBit_d  = outBit_q;
      intSck_d  = intSck_q;
      irq_d     = 1'b0;
      byteDone  = 1'b0;
      unique case (state_q)
         SSP_IDLE: begin
            intSck_d = 1'b1;
         end
         SSP_PEND: begin
            // a full receive queue holds the byte back here
            intSck_d = 1'b1;
            if (fifoReady) begin
               state_d = SSP_SHIFT;
            end
         end
         SSP_SHIFT: begin
            if (!extClk && prescTick) begin
               intSck_d = ~intSck_q;
            end
            if (sckFall) begin
               // one output bit feeds both data pins
               outBit_d = MSB_FIRST ? shift_q[7] : shift_q[0];
            end
            if (sckRise) begin
               if (MSB_FIRST) begin
                  shift_d = {shift_q[6:0], datS2_q};
               end else begin
                  shift_d = {datS2_q, shift_q[7:1]};
               end
               bitCnt_d = bitCnt_q + 3'h1;
               if (bitCnt_q == SSP_LAST_BIT) begin
                  byteDone  = 1'b1;
                  state_d   = SSP_IDLE;
                  endFlag_d = 1'b1;
                  irq_d     = 1'b1;
               end
            end
         end
      endcase
      if (ctrlWr) begin
         ctrl_d   = regWdata[SSP_CTRL_DIR_BIT:SSP_CTRL_EXTCLK_BIT];
         state_d  = SSP_IDLE;
         bitCnt_d = 3'h0;
         intSck_d = 1'b1;
         if (regWdata[SSP_CTRL_START_BIT]) begin
            state_d = SSP_PEND;
            guard_d = SSP_GUARD_LOAD;
            if (!byteDone) begin
               endFlag_d = 1'b0;
            end
         end
      end
      if (dataWr) begin
         state_d  = SSP_IDLE;
         bitCnt_d = 3'h0;
         intSck_d = 1'b1;
         if (ptrLsb) begin
            shift_d[7:4] = regWdata;
         end else begin
            shift_d[3:0] = regWdata;
         end
      end
   end

   // read data is captured on the clock edge that sees the read strobe
   always_comb begin
      rdata_d = rdata_q;
      if (regRead) begin
         if (regAddr == SSP_CTRL_ADDR) begin
            rdata_d = {ctrl_q, endFlag_q};
         end else if (regAddr == SSP_DATA_ADDR) begin
            rdata_d = ptrLsb ? shift_q[7:4] : shift_q[3:0];
         end else begin
            rdata_d = 4'h0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state_q   <= SSP_IDLE;
         ctrl_q    <= SSP_CTRL_RESET;
         shift_q   <= SSP_DATA_RESET;
         bitCnt_q  <= 3'h0;
         guard_q   <= 4'h0;
         endFlag_q <= 1'b0;
         outBit_q  <= 1'b1;
         intSck_q  <= 1'b1;
         irq_q     <= 1'b0;
         rdata_q   <= SSP_RDATA_RESET;
      end else begin
         state_q   <= state_d;
         ctrl_q    <= ctrl_d;
         shift_q   <= shift_d;
         bitCnt_q  <= bitCnt_d;
         guard_q   <= guard_d;
         endFlag_q <= endFlag_d;
         outBit_q  <= outBit_d;
         intSck_q  <= intSck_d;
         irq_q     <= irq_d;
         rdata_q   <= rdata_d;
      end
   end

   // ==========================================================
   // receive queue: every finished byte is offered to the core side
   ssp_fifo #(
      .WIDTH (SSP_BYTE_BITS),
      .DEPTH (FIFO_DEPTH)
   ) rxQueue (
      .clk      (clk),
      .reset    (reset),
      .inData   (shift_d),
      .inValid  (byteDone),
      .inReady  (fifoReady),
      .outData  (rxByte),
      .outValid (rxValid),
      .outReady (rxReady)
   );

   // ==========================================================
   // pins
   assign sckOut       = intSck_q;
   assign sckOe        = ~extClk;
   assign serialOutPin = outBit_q;
   assign bidirDataOut = outBit_q;
   assign bidirDataOe  = ctrl_q[SSP_CTRL_DIR_BIT - 1];
   assign serialIrq    = irq_q;
   assign regRdata     = rdata_q;

endmodule // ssp_serial_port

`default_nettype wire

// file: verification/ssp_serial_port_chk.sv
// port checker of the serial shift port, bound into its top module
`timescale 1ns/1ps
`default_nettype none

module ssp_serial_port_chk
   import ssp_pkg::*;
(
   input wire logic       clk,
   input wire logic       reset,
   input wire logic [3:0] regAddr,
   input wire logic       regWrite,
   input wire logic       regRead,
   input wire logic [3:0] regWdata,
   input wire logic [3:0] regRdata,
   input wire logic       prescalerStop,
   input wire logic       sckOut,
   input wire logic       sckOe,
   input wire logic       serialOutPin,
   input wire logic       bidirDataOut,
   input wire logic       bidirDataOe,
   input wire logic       serialIrq,
   input wire logic       rxValid,
   input wire logic       rxReady
);
   logic sckPrev_q;
   logic fell_q;
   logic fellNow;
   logic ctrlWr;

   // ======
   // falling clock edges now and one cycle back; data may lag one flop
   assign fellNow = sckPrev_q & ~sckOut;
   assign ctrlWr = regWrite && regAddr == SSP_CTRL_ADDR;
   always_ff @(posedge clk) begin
      sckPrev_q <= sckOut;
      fell_q    <= fellNow;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   // ======
   // pin levels, control decode and shift timing
   rst_idle_a: assert property (
      $fell(reset) |-> sckOut && serialOutPin && !bidirDataOe && !serialIrq)
      else $error("pins not idle after reset");
   ext_sel_a: assert property (
      ctrlWr |=> sckOe == !$past(regWdata[SSP_CTRL_EXTCLK_BIT]))
      else $error("clock pin drive does not follow control");
   dir_sel_a: assert property (
      ctrlWr |=> bidirDataOe == $past(regWdata[SSP_CTRL_DIR_BIT]))
      else $error("data pin direction does not follow control");
   irq_once_a: assert property (
      serialIrq |=> !serialIrq) else $error("irq longer than a cycle");
   irq_byte_a: assert property (
      serialIrq |-> sckOut ##[0:3] rxValid)
      else $error("irq without idle clock or stored byte");
   stop_hold_a: assert property (
      prescalerStop && $past(prescalerStop) && sckOe |-> $stable(sckOut))
      else $error("clock moved while prescaler stopped");
   out_fall_a: assert property (
      sckOe && $changed(serialOutPin) |-> fellNow || fell_q)
      else $error("serial out changed off a falling edge");
   same_bit_a: assert property (
      bidirDataOut == serialOutPin) else $error("data outputs differ");
   unmapped_a: assert property (
      regRead && regAddr != SSP_CTRL_ADDR && regAddr != SSP_DATA_ADDR
      |=> regRdata == SSP_RDATA_RESET) else $error("unmapped read not zero");

   cover property (serialIrq && !sckOe);
   cover property (rxValid && rxReady);
   cover property (prescalerStop && sckOe);
endmodule  // ssp_serial_port_chk

bind ssp_serial_port ssp_serial_port_chk ssp_serial_port_chk_i (
   .clk(clk), .reset(reset), .regAddr(regAddr), .regWrite(regWrite),
   .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata),
   .prescalerStop(prescalerStop), .sckOut(sckOut), .sckOe(sckOe),
   .serialOutPin(serialOutPin), .bidirDataOut(bidirDataOut),
   .bidirDataOe(bidirDataOe), .serialIrq(serialIrq), .rxValid(rxValid),
   .rxReady(rxReady));
`default_nettype wire

// file: verification/ssp_peer.sv
// behavioural far-side serial peer: clocks, sends and takes one byte
`timescale 1ns/1ps
`default_nettype none

module ssp_peer (
   input  wire logic       clk,
   input  wire logic       go,
   input  wire logic       ext,
   input  wire logic [7:0] txByte,
   input  wire logic       sckLine,
   input  wire logic       rxPin,
   output var  logic       sckDrv,
   output var  logic       dataOut,
   output var  logic [7:0] rxSh
);
   logic [7:0] sh;
   logic       sckPrev = 1'b1;
   int         cnt = 8;

   initial begin
      sckDrv = 1'b1;
      dataOut = 1'b0;
      rxSh = 8'h00;
   end

   // ======
   // load on go; own clock only when external, well under 500 kHz;
   // on the port's clock drive after a fall and take after a rise
   always @(posedge clk) begin
      sckPrev <= sckLine;
      if (go) begin
         sh <= txByte;
         cnt <= ext ? 8 : 0;
         if (ext) begin
            repeat (20) @(posedge clk);
            repeat (8) begin
               repeat (30) @(posedge clk);
               sckDrv <= 1'b0;
               dataOut <= sh[7];
               sh <= sh << 1;
               repeat (30) @(posedge clk);
               sckDrv <= 1'b1;
               rxSh <= {rxSh[6:0], rxPin};
            end
            // hold the last bit while the port's synchroniser takes it
            repeat (4) @(posedge clk);
         end
      end else if (cnt < 8) begin
         if (sckPrev && !sckLine) begin
            dataOut <= sh[7];
            sh <= sh << 1;
         end
         if (!sckPrev && sckLine) begin
            rxSh <= {rxSh[6:0], rxPin};
            cnt <= cnt + 1;
         end
      end else begin
         dataOut <= ~dataOut;  // outside a frame the line is not trustworthy
      end
   end
endmodule  // ssp_peer
`default_nettype wire

// file: verification/test_ssp_serial_port.sv
// self-checking bench of the serial shift port with a serial peer
`timescale 1ns/1ps
`default_nettype none

module test_ssp_serial_port;
   import ssp_pkg::*;
   logic       clk = 1'b0, reset = 1'b1, regWrite = 1'b0, regRead = 1'b0;
   logic       ptrLsb = 1'b0, prescalerStop = 1'b0, rxReady = 1'b1;
   logic       go = 1'b0, ext = 1'b0, rdPend_q = 1'b0;
   logic [3:0] regAddr = 4'h0, regWdata = 4'h0, regRdata;
   logic       sckOut, sckOe, serialOutPin, bidirDataOut, bidirDataOe;
   logic       serialIrq, rxValid, sckDrv, peerData;
   logic [7:0] rxByte, peerRx, peerTx = 8'h00;
   logic [31:0] seed = 32'd45;
   logic [7:0] rxQ[$];
   logic [3:0] rdQ[$];
   logic [3:0] modes[4] = '{4'h0, 4'h8, 4'h2, 4'ha};
   int         err_count = 0, cmp_count = 0, irqCnt = 0;
   wire        sckLine = sckOe ? sckOut : sckDrv;
   wire        dataLine = bidirDataOe ? bidirDataOut : peerData;

   always #20 clk = ~clk;

   ssp_serial_port #(.MSB_FIRST(1'b1), .PRESC_DIV(2), .FIFO_DEPTH(16))
      ssp_serial_port_i (.clk(clk), .reset(reset), .regAddr(regAddr),
      .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata),
      .ptrLsb(ptrLsb), .regRdata(regRdata), .prescalerStop(prescalerStop),
      .sckIn(sckLine), .sckOut(sckOut), .sckOe(sckOe),
      .serialOutPin(serialOutPin), .bidirDataIn(dataLine),
      .bidirDataOut(bidirDataOut), .bidirDataOe(bidirDataOe),
      .serialIrq(serialIrq), .rxByte(rxByte), .rxValid(rxValid),
      .rxReady(rxReady));
   ssp_peer ssp_peer_i (.clk(clk), .go(go), .ext(ext), .txByte(peerTx),
      .sckLine(sckLine), .rxPin(bidirDataOe ? dataLine : serialOutPin),
      .sckDrv(sckDrv), .dataOut(peerData), .rxSh(peerRx));

   // ======
   // helpers: random source, compare, register cycles
   function automatic logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [3:0] d, input logic p);
      @(negedge clk);
      regAddr = a;
      regWdata = d;
      ptrLsb = p;
      regWrite = 1'b1;
      @(negedge clk);
      regWrite = 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic p, input logic [3:0] e);
      @(negedge clk);
      regAddr = a;
      ptrLsb = p;
      regRead = 1'b1;
      rdQ.push_back(e);
      @(negedge clk);
      regRead = 1'b0;
   endtask
   task automatic waitIrq(input int lim);
      int n;
      n = irqCnt;
      repeat (lim) if (irqCnt == n) @(negedge clk);
      chk(8'(irqCnt - n), 8'h01);
   endtask
   // one byte in mode m; the byte taken is the peer's, or our own on 2-wire
   task automatic xfer(input logic [3:0] m, input logic w);
      logic [7:0] t;
      logic [7:0] r;
      t = rnd();
      peerTx = rnd();
      r = m[3] ? t : peerTx;
      ext = m[1];
      rxQ.push_back(r);
      wr(SSP_DATA_ADDR, t[3:0], 1'b0);
      wr(SSP_DATA_ADDR, t[7:4], 1'b1);
      wr(SSP_CTRL_ADDR, m, 1'b0);
      wr(SSP_CTRL_ADDR, m | 4'h1, 1'b0);
      go = 1'b1;
      @(negedge clk);
      go = 1'b0;
      rd(SSP_CTRL_ADDR, 1'b0, m);
      if (w) begin
         waitIrq(900);
         chk(peerRx, t);
         rd(SSP_CTRL_ADDR, 1'b0, m | 4'h1);
         rd(SSP_DATA_ADDR, 1'b0, r[3:0]);
         rd(SSP_DATA_ADDR, 1'b1, r[7:4]);
      end
   endtask
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // ======
   // watcher: settled read data and popped bytes against the oldest note
   always @(posedge clk) begin
      if (rdPend_q) begin
         chk({4'h0, regRdata}, {4'h0, rdQ.pop_front()});
      end
      if (rxValid && rxReady) begin
         chk(rxByte, rxQ.size() ? rxQ.pop_front() : ~rxByte);
      end
      if (serialIrq === 1'b1) irqCnt <= irqCnt + 1;
      rdPend_q <= regRead;
   end

   initial begin
      #(40 * 30000);
      err_count++;
      finish_test();
   end

   initial begin
      logic [7:0] t;
      int n;
      repeat (16) @(negedge clk);
      reset = 1'b0;
      rd(SSP_CTRL_ADDR, 1'b0, 4'h0);
      rd(SSP_DATA_ADDR, 1'b1, 4'h0);
      wr(4'h7, 4'hf, 1'b0);
      rd(4'h7, 1'b0, 4'h0);
      $display("register test done");
      for (int i = 0; i < 4; i++) xfer(modes[i], 1'b1);
      $display("mode test done");
      n = irqCnt;
      prescalerStop = 1'b1;
      xfer(4'h0, 1'b0);
      repeat (200) @(negedge clk);
      chk(8'(irqCnt - n), 8'h00);
      prescalerStop = 1'b0;
      waitIrq(400);
      $display("prescaler test done");
      wr(SSP_CTRL_ADDR, 4'h1, 1'b0);
      repeat (30) @(negedge clk);
      n = irqCnt;
      wr(SSP_DATA_ADDR, 4'h5, 1'b0);
      repeat (300) @(negedge clk);
      chk(8'(irqCnt - n), 8'h00);
      rd(SSP_CTRL_ADDR, 1'b0, 4'h0);
      $display("abort test done");
      rxReady = 1'b0;
      repeat (16) xfer(4'h0, 1'b1);
      n = irqCnt;
      xfer(4'h0, 1'b0);
      repeat (300) @(negedge clk);
      chk(8'(irqCnt - n), 8'h00);
      repeat (150) begin
         @(negedge clk);
         t = rnd();
         rxReady = t[0];
      end
      rxReady = 1'b1;
      repeat (60) @(negedge clk);
      chk(8'(irqCnt - n), 8'h01);
      chk(8'(rxQ.size()), 8'h00);
      $display("buffer test done");
      finish_test();
   end
endmodule  // test_ssp_serial_port
`default_nettype wire
